// [pkg/mcrs_regs.svh]
// Purpose: constants of the module call and return sequencer
// Assumes: 32-bit long words, big-endian byte order
// Notes:   definitions only
`ifndef MCRS_REGS_SVH
`define MCRS_REGS_SVH

`define OPT_STACK      3'h0
`define OPT_INDIRECT   3'h4
`define TYPE_PLAIN     5'h00
`define TYPE_ACCESS    5'h01
`define DESC_ENTRY_OFS 32'h0000_0004
`define DESC_DAP_OFS   32'h0000_0008
`define DESC_SP_OFS    32'h0000_000c
`define FRAME_BYTES    32'h0000_0018
`define FRAME_LAST     3'h5
`define DESC_LAST      3'h3
`define ENTRY_STEP     32'h0000_0002
`define EREG_SP        4'hf
`define AL_BASE        32'h0001_0000
`define AL_CAL         32'h0000_0000
`define AL_STAT        32'h0000_0004
`define AL_IAL         32'h0000_0008
`define AL_DAL         32'h0000_000c
`define AL_DADDR       32'h0000_0040
`define AL_SPACE       4'h1
`define ST_REFUSE      8'h00
`define ST_SP_MIN      8'h04
`define ST_MAX         8'h07

`endif

// [pkg/mcrs_pkg.sv]
// Purpose: types of the module call and return sequencer
// Assumes: nothing beyond the constants header
// Notes:   structs carry the command, bus request and result
package mcrs_pkg;

    typedef enum logic [3:0] {
        S_IDLE, S_DESC, S_ENTRY, S_CAL, S_DADDR, S_IAL, S_STAT,
        S_CPYR, S_CPYW, S_FRAME, S_RFRAME, S_DAL, S_RSTAT
    } seq_state_e;

    typedef struct packed {
        logic        ret;        // 1: module return, 0: module call
        logic [31:0] desc_addr;  // call: descriptor address
        logic [31:0] sp;         // caller stack pointer / frame base on return
        logic [31:0] pc_next;    // address after the call instruction
        logic [7:0]  condition_code_bits;        // condition code bits
        logic [2:0]  fc;         // function code of the caller
    } seq_cmd_s;

    typedef struct packed {
        logic        we;
        logic        cpu;        // processor-space access
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic [31:0] sp;
        logic [31:0] pc;
        logic [7:0]  condition_code_bits;
        logic        ccr_we;
        logic [3:0]  reg_sel;
        logic [31:0] reg_val;
        logic        reg_we;
    } seq_res_s;

endpackage

// [logic/module_call_return_sequencer.sv]
// Purpose: sequences module call and module return instructions
// Assumes: descriptor, frame and entry word long-word aligned; mem_ack/mem_berr on clk
// Notes:   one bus access in flight at a time; results presented with done
// Contract
// [R1] descriptor long word zero holds control
// [R2] only options 000 and 100 accepted
// [R3] option 000 copies arguments on stack switch
// [R4] option 100 stores caller stack pointer
// [R5] only types 00 and 01 accepted
// [R6] type 00 keeps rights, caller stack
// [R7] type 01 may change rights and stack
// [R8] access level forwarded only for type 01
// [R9] entry word selects register; code follows
// [R10] stack switch saves old, loads descriptor value
// [R11] user types 10 to 1F fault
// [R12] stack pointer register overrides data pointer
// [R13] call builds frame, return removes it
// [R14] frame keeps address after call
// [R15] option and type copied, checked on return
// [R16] access level saved and restored externally
// [R17] argument count pops caller arguments on return
// [R18] condition codes saved and restored
// [R19] frame holds start stack and data pointer
// [R20] access exchanges use processor space 0001
// [R21] refused change gives format error
// [R22] faults abort before any frame write
`timescale 1ns/1ps
`include "mcrs_regs.svh"

module module_call_return_sequencer
    import mcrs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire seq_cmd_s    cmd,
    output logic             mem_valid,
    output mem_req_s         mem,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    input  wire logic        mem_berr,
    output logic [3:0]       reg_rd_sel,
    input  wire logic [31:0] reg_rd_val,
    output logic             done,
    output logic             fmt_err,
    output logic             bus_err,
    output seq_res_s         res
);

    seq_state_e  state_r;
    seq_cmd_s    cmd_r;
    logic [2:0]  opt_r;
    logic [4:0]  type_r;
    logic [7:0]  al_r;
    logic [7:0]  cal_r;
    logic [7:0]  argc_r;
    logic [7:0]  ccr_r;
    logic [3:0]  ereg_r;
    logic [31:0] entry_r;
    logic [31:0] dap_r;
    logic [31:0] dsp_r;
    logic [31:0] tmp_r;
    logic [6:0]  cnt_r;
    logic        sw_r;
    logic        done_r;
    logic        fmt_r;
    logic        berr_r;
    seq_res_s    res_r;

    // decoding of the word on the bus and of the held fields
    wire         step     = mem_valid && (mem_ack || mem_berr);
    wire         good     = mem_valid && mem_ack && !mem_berr;
    wire  [2:0]  rd_opt   = mem_rdata[31:29];
    wire  [4:0]  rd_type  = mem_rdata[28:24];
    wire  [7:0]  rd_st    = mem_rdata[31:24];
    wire         opt_ok   = (rd_opt == `OPT_STACK) || (rd_opt == `OPT_INDIRECT); // R2
    // anything but 00/01, user types 10-1F included, is a format error
    wire         type_ok  = (rd_type == `TYPE_PLAIN) || (rd_type == `TYPE_ACCESS); // R5 R11
    wire         st_bad   = (rd_st == `ST_REFUSE) || (rd_st > `ST_MAX); // R21
    wire         st_sw    = (rd_st >= `ST_SP_MIN);
    wire         is_acc   = (type_r == `TYPE_ACCESS);
    wire  [6:0]  nlongs   = 7'((({1'b0, argc_r}) + 9'h3) >> 2);
    wire  [31:0] cbytes   = {23'h0, nlongs, 2'b00};
    wire         copy_on  = sw_r && (opt_r == `OPT_STACK) && (nlongs != 7'h0); // R3
    wire  [31:0] idx4     = {23'h0, cnt_r, 2'b00};
    // new stack only on a granted switch, else the caller's
    wire  [31:0] top_w    = sw_r ? (copy_on ? dsp_r - cbytes : dsp_r) : cmd_r.sp; // R6 R7 R10
    wire  [31:0] fb_w     = top_w - `FRAME_BYTES;
    wire  [31:0] al_addr  = `AL_BASE | `AL_DADDR | {27'h0, cmd_r.fc, 2'b00};
    // saved stack pointer: caller value at the start of the call
    wire  [31:0] fw0      = {opt_r, type_r, cal_r, 16'h0000}; // R15 R16
    wire  [31:0] fw1      = {argc_r, ccr_r, ereg_r, 12'h000}; // R17 R18
    wire  [31:0] frame_wd = (cnt_r == 7'h0) ? fw0 :
                            (cnt_r == 7'h1) ? fw1 :
                            (cnt_r == 7'h2) ? cmd_r.desc_addr :  // R13
                            (cnt_r == 7'h3) ? cmd_r.pc_next :    // R14
                            (cnt_r == 7'h4) ? cmd_r.sp :         // R4 R10 R19
                                              reg_rd_val;        // R19
    wire         fr_last  = (cnt_r[2:0] == `FRAME_LAST);

    assign cmd_ready  = (state_r == S_IDLE);
    assign mem_valid  = (state_r != S_IDLE);
    assign reg_rd_sel = ereg_r;
    assign done       = done_r;
    assign fmt_err    = fmt_r;
    assign bus_err    = berr_r;
    assign res        = res_r;

    always_comb begin
        mem = '0;
        unique case (state_r)
            S_IDLE:   mem = '0;
            S_DESC:   mem.addr = cmd_r.desc_addr + idx4; // R1
            S_ENTRY:  mem.addr = entry_r; // R9
            S_CAL:    mem = '{we: 1'b0, cpu: 1'b1, addr: `AL_BASE | `AL_CAL, wdata: 32'h0};
            S_DADDR:  mem = '{we: 1'b1, cpu: 1'b1, addr: al_addr, wdata: cmd_r.desc_addr};
            S_IAL:    mem = '{we: 1'b1, cpu: 1'b1, addr: `AL_BASE | `AL_IAL,
                              wdata: {al_r, 24'h0}}; // R8 R20
            S_STAT,
            S_RSTAT:  mem = '{we: 1'b0, cpu: 1'b1, addr: `AL_BASE | `AL_STAT, wdata: 32'h0};
            S_CPYR:   mem.addr = cmd_r.sp + idx4; // R3
            S_CPYW:   mem = '{we: 1'b1, cpu: 1'b0, addr: top_w + idx4, wdata: tmp_r}; // R3
            S_FRAME:  mem = '{we: 1'b1, cpu: 1'b0, addr: fb_w + idx4, wdata: frame_wd}; // R13
            S_RFRAME: mem.addr = cmd_r.sp + idx4; // R13
            S_DAL:    mem = '{we: 1'b1, cpu: 1'b1, addr: `AL_BASE | `AL_DAL,
                              wdata: {cal_r, 24'h0}}; // R16 R20
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            cmd_r   <= '0;
            opt_r   <= 3'h0;
            type_r  <= 5'h00;
            al_r    <= 8'h00;
            cal_r   <= 8'h00;
            argc_r  <= 8'h00;
            ccr_r   <= 8'h00;
            ereg_r  <= 4'h0;
            entry_r <= 32'h0;
            dap_r   <= 32'h0;
            dsp_r   <= 32'h0;
            tmp_r   <= 32'h0;
            cnt_r   <= 7'h0;
            sw_r    <= 1'b0;
            done_r  <= 1'b0;
            fmt_r   <= 1'b0;
            berr_r  <= 1'b0;
            res_r   <= '0;
        end else begin
            done_r <= 1'b0;
            fmt_r  <= 1'b0;
            berr_r <= 1'b0;
            if (state_r == S_IDLE) begin
                if (cmd_valid) begin
                    cmd_r   <= cmd;
                    ccr_r   <= cmd.condition_code_bits;
                    cal_r   <= 8'h00;
                    sw_r    <= 1'b0;
                    cnt_r   <= 7'h0;
                    state_r <= cmd.ret ? S_RFRAME : S_DESC;
                end
            end else if (step && mem_berr) begin
                // a fault on an access-level exchange is a format error
                fmt_r   <= mem.cpu; // R22
                berr_r  <= !mem.cpu;
                done_r  <= 1'b1;
                state_r <= S_IDLE;
            end else if (good) begin
                unique case (state_r)
                    S_DESC: begin
                        cnt_r <= cnt_r + 7'h1;
                        if (cnt_r == 7'h0) begin
                            opt_r  <= rd_opt; // R1
                            type_r <= rd_type;
                            al_r   <= mem_rdata[23:16];
                            argc_r <= mem_rdata[7:0];
                            if (!opt_ok || !type_ok) begin
                                fmt_r   <= 1'b1; // R2 R5 R11 R22
                                done_r  <= 1'b1;
                                state_r <= S_IDLE;
                            end
                        end else if (cnt_r == 7'h1) begin
                            entry_r <= mem_rdata;
                        end else if (cnt_r == 7'h2) begin
                            dap_r <= mem_rdata;
                        end else begin
                            dsp_r   <= mem_rdata; // R10
                            cnt_r   <= 7'h0;
                            state_r <= S_ENTRY;
                        end
                    end
                    S_ENTRY: begin
                        // entry word sits in the upper half of the long word
                        ereg_r  <= mem_rdata[31:28]; // R9
                        state_r <= is_acc ? S_CAL : S_FRAME; // R6 R7
                    end
                    S_CAL: begin
                        cal_r   <= rd_st; // R16
                        state_r <= S_DADDR;
                    end
                    S_DADDR: state_r <= S_IAL;
                    S_IAL:   state_r <= S_STAT;
                    S_STAT: begin
                        if (st_bad) begin
                            fmt_r   <= 1'b1; // R21 R22
                            done_r  <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            sw_r <= st_sw; // R10
                            if (st_sw && (opt_r == `OPT_STACK) && (nlongs != 7'h0)) begin
                                state_r <= S_CPYR; // R3
                            end else begin
                                state_r <= S_FRAME;
                            end
                        end
                    end
                    S_CPYR: begin
                        tmp_r   <= mem_rdata;
                        state_r <= S_CPYW;
                    end
                    S_CPYW: begin
                        if (cnt_r == nlongs - 7'h1) begin
                            cnt_r   <= 7'h0;
                            state_r <= S_FRAME;
                        end else begin
                            cnt_r   <= cnt_r + 7'h1;
                            state_r <= S_CPYR;
                        end
                    end
                    S_FRAME: begin
                        cnt_r <= cnt_r + 7'h1;
                        if (fr_last) begin
                            res_r.sp      <= fb_w;
                            res_r.pc      <= entry_r + `ENTRY_STEP; // R9
                            res_r.condition_code_bits     <= ccr_r;
                            res_r.ccr_we  <= 1'b0;
                            res_r.reg_sel <= ereg_r;
                            // data pointer yields to the real stack pointer
                            res_r.reg_val <= (ereg_r == `EREG_SP) ? fb_w : dap_r; // R12
                            res_r.reg_we  <= 1'b1;
                            done_r        <= 1'b1;
                            state_r       <= S_IDLE;
                        end
                    end
                    S_RFRAME: begin
                        cnt_r <= cnt_r + 7'h1;
                        if (cnt_r == 7'h0) begin
                            opt_r  <= rd_opt;
                            type_r <= rd_type;
                            cal_r  <= mem_rdata[23:16]; // R16
                            if (!opt_ok || !type_ok) begin
                                fmt_r   <= 1'b1; // R15 R22
                                done_r  <= 1'b1;
                                state_r <= S_IDLE;
                            end
                        end else if (cnt_r == 7'h1) begin
                            argc_r <= mem_rdata[31:24]; // R17
                            ccr_r  <= mem_rdata[23:16]; // R18
                            ereg_r <= mem_rdata[15:12];
                        end else if (cnt_r == 7'h3) begin
                            entry_r <= mem_rdata;
                        end else if (cnt_r == 7'h4) begin
                            dsp_r <= mem_rdata; // R19
                        end else if (fr_last) begin
                            dap_r   <= mem_rdata; // R19
                            state_r <= is_acc ? S_DAL : S_IDLE;
                            done_r  <= !is_acc;
                        end
                    end
                    S_DAL: state_r <= S_RSTAT;
                    S_RSTAT: begin
                        fmt_r   <= st_bad; // R21
                        done_r  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                    default: state_r <= S_IDLE;
                endcase
                // a type 01 return waits for the status, so a refusal publishes nothing
                if ((state_r == S_RFRAME && fr_last && !is_acc) ||
                    (state_r == S_RSTAT && !st_bad)) begin // R22
                    res_r.sp      <= dsp_r + {24'h0, argc_r}; // R17 R19
                    res_r.pc      <= entry_r;
                    res_r.condition_code_bits     <= ccr_r; // R18
                    res_r.ccr_we  <= 1'b1;
                    res_r.reg_sel <= ereg_r;
                    res_r.reg_val <= (state_r == S_RFRAME) ? mem_rdata : dap_r;
                    res_r.reg_we  <= 1'b1;
                end
            end
        end
    end

    property p_opt_check;
        @(posedge clk) disable iff (rst)
        (state_r == S_DESC && cnt_r == 7'h0 && good && !opt_ok) |=> (fmt_err && done);
    endproperty
    a_opt_check: assert property (p_opt_check) else $error("bad option not faulted"); // R2

    property p_type_check;
        @(posedge clk) disable iff (rst)
        (state_r == S_RFRAME && cnt_r == 7'h0 && good && !type_ok) |=> (fmt_err && done);
    endproperty
    a_type_check: assert property (p_type_check) else $error("bad frame type not faulted"); // R15

    property p_refuse;
        @(posedge clk) disable iff (rst)
        (state_r == S_STAT && good && rd_st == `ST_REFUSE) |=> (fmt_err && state_r == S_IDLE);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused change not faulted"); // R21

    property p_no_result_on_fault;
        @(posedge clk) disable iff (rst)
        (done && fmt_err) |-> $stable(res_r);
    endproperty
    a_no_result_on_fault: assert property (p_no_result_on_fault) else $error("fault changed result"); // R22

    property p_cpu_space;
        @(posedge clk) disable iff (rst)
        (mem_valid && mem.cpu) |-> (mem.addr[19:16] == `AL_SPACE);
    endproperty
    a_cpu_space: assert property (p_cpu_space) else $error("processor space code wrong"); // R20

    property p_frame_pc;
        @(posedge clk) disable iff (rst)
        (state_r == S_FRAME && cnt_r == 7'h3) |-> (mem.we && mem.wdata == cmd_r.pc_next);
    endproperty
    a_frame_pc: assert property (p_frame_pc) else $error("frame pc wrong"); // R14

    property p_sp_override;
        @(posedge clk) disable iff (rst)
        (state_r == S_FRAME && fr_last && good && ereg_r == `EREG_SP)
            |=> (done && res.reg_val == res.sp);
    endproperty
    a_sp_override: assert property (p_sp_override) else $error("stack register not overridden"); // R12

    property p_ret_pop;
        @(posedge clk) disable iff (rst)
        (done && !fmt_err && !bus_err && cmd_r.ret) |-> (res.sp == dsp_r + {24'h0, argc_r});
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("argument count not popped"); // R17

    property p_level_plain;
        @(posedge clk) disable iff (rst)
        (mem_valid && mem.cpu) |-> is_acc;
    endproperty
    a_level_plain: assert property (p_level_plain) else $error("level exchange on type 00"); // R8

endmodule

// [dv/access_mem_model.sv]
// Purpose: memory and access-control partner of the sequencer
// Assumes: one access in flight, answered after 0..3 wait cycles
// Notes:   unanswered cycles show the inverse of the last data
`timescale 1ns/1ps
`include "mcrs_regs.svh"
module access_mem_model
    import mcrs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        mem_valid,
    input  wire mem_req_s    mem,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack,
    output logic             mem_berr,
    input  wire logic [7:0]  cal_lvl,
    input  wire logic [7:0]  status,
    input  wire logic [31:0] berr_at
);
    logic [31:0] store [logic [31:0]];
    logic [31:0] cst [logic [31:0]];
    logic [1:0]  wait_r;

    function automatic logic [31:0] rd_val(input mem_req_s q, input logic [31:0] last);
        if (q.cpu && q.addr == `AL_BASE + `AL_CAL)
            return {cal_lvl, 24'h0};
        if (q.cpu && q.addr == `AL_BASE + `AL_STAT)
            return {status, 24'h0};
        if (!q.cpu && store.exists(q.addr))
            return store[q.addr];
        return ~last;
    endfunction

    always @(posedge clk) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_berr <= 1'b0;
            mem_rdata <= 32'h0;
            wait_r <= 2'h0;
        end else if (mem_ack || mem_berr) begin
            mem_ack <= 1'b0;
            mem_berr <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_r <= 2'($urandom_range(3, 0));
        end else if (mem_valid && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
            mem_rdata <= ~mem_rdata;
        end else if (mem_valid) begin
            // wrong space is refused like absent hardware
            if (mem.addr == berr_at || (mem.cpu && mem.addr[19:16] != `AL_SPACE)) begin
                mem_berr <= 1'b1;
            end else begin
                mem_ack <= 1'b1;
                mem_rdata <= rd_val(mem, mem_rdata);
                if (mem.we && mem.cpu)
                    cst[mem.addr] = mem.wdata;
                else if (mem.we)
                    store[mem.addr] = mem.wdata;
            end
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// [dv/tb_top.sv]
// Purpose: self-checking bench of the module call and return sequencer
// Assumes: every good call is followed by a return of its frame
// Notes:   descriptor, entry and new stack sit at fixed places; the caller stack is placed at random
`timescale 1ns/1ps
`include "mcrs_regs.svh"
module tb_top
    import mcrs_pkg::*;
;
    localparam logic [31:0] DSC = 32'h0000_4000;
    localparam logic [31:0] ENT = 32'h0000_8000;
    localparam logic [31:0] DAP = 32'h0000_9000;
    localparam logic [31:0] DSP = 32'h0004_0000;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    seq_cmd_s    cmd = '0;
    logic        cmd_ready, mem_valid, mem_ack, mem_berr, done, fmt_err, bus_err;
    mem_req_s    mem;
    logic [31:0] mem_rdata;
    logic [3:0]  reg_rd_sel;
    logic [31:0] reg_rd_val = 32'h0;
    seq_res_s    res, got;
    logic [7:0]  cal_lvl = 8'h0;
    logic [7:0]  status = 8'h1;
    logic [31:0] berr_at = 32'hffff_fff0;
    logic        g_fmt, g_bus;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #2 clk = ~clk;

    module_call_return_sequencer dut_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .mem_valid(mem_valid), .mem(mem),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_berr(mem_berr),
        .reg_rd_sel(reg_rd_sel), .reg_rd_val(reg_rd_val), .done(done),
        .fmt_err(fmt_err), .bus_err(bus_err), .res(res));

    access_mem_model mp_u (.clk(clk), .rst(rst), .mem_valid(mem_valid), .mem(mem),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_berr(mem_berr),
        .cal_lvl(cal_lvl), .status(status), .berr_at(berr_at));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic run(input seq_cmd_s c);
        int k;
        @(posedge clk);
        cmd <= c;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (k = 0; k < 2000 && done !== 1'b1; k++)
            @(negedge clk);
        g_fmt = fmt_err;
        g_bus = bus_err;
        got = res;
        chk("idle", 32'({cmd_ready, mem_valid}), 32'h2);
        if (k == 2000)
            chk("done", 32'h0, 32'h1);
    endtask

    function automatic logic bad_fmt(input logic [2:0] o, input logic [4:0] t,
                                     input logic [7:0] s);
        return !(o == `OPT_STACK || o == `OPT_INDIRECT) || t > `TYPE_ACCESS
            || (t == `TYPE_ACCESS && (s == `ST_REFUSE || s > `ST_MAX));
    endfunction

    // bk: 0 no fault, 1 normal-space bus error, 2 processor-space bus error
    task automatic call_case(input logic [2:0] o, input logic [4:0] t, input logic [7:0] s,
        input logic [3:0] rg, input logic [7:0] ac, input int bk, input logic br);
        logic [31:0] sp, fb, top, rv;
        logic [7:0]  cl, lv, cc;
        logic        fe, sw;
        int          n;
        seq_cmd_s    c;
        sp = 32'h0002_0000 + 32'($urandom_range(255, 0) << 4);
        lv = 8'($urandom);
        cl = 8'($urandom);
        cc = 8'($urandom);
        rv = $urandom;
        mp_u.store[DSC] = {o, t, lv, 8'h0, ac};
        mp_u.store[DSC + 4] = ENT;
        mp_u.store[DSC + 8] = DAP;
        mp_u.store[DSC + 12] = DSP;
        mp_u.store[ENT] = {rg, 28'h0};
        for (n = 0; n < 4; n++)
            mp_u.store[sp + 4 * n] = $urandom;
        mp_u.store[sp - 4] = 32'h5a5a_5a5a;
        mp_u.store[DSP - 4] = 32'h5a5a_5a5a;
        mp_u.cst.delete();
        status <= s;
        cal_lvl <= cl;
        berr_at <= bk == 1 ? DSC + 8 : bk == 2 ? `AL_BASE + `AL_STAT : 32'hffff_fff0;
        c = '0;
        c.desc_addr = DSC;
        c.sp = sp;
        c.pc_next = $urandom & 32'hffff_fffe;
        c.condition_code_bits = cc;
        c.fc = 3'($urandom_range(7, 0));
        @(posedge clk);
        reg_rd_val <= rv;
        run(c);
        fe = bad_fmt(o, t, s) || bk == 2;
        chk("fmt_err", 32'(g_fmt), 32'(fe));
        chk("bus_err", 32'(g_bus), 32'(bk == 1 && !fe));
        if (g_fmt !== 1'b0 || g_bus !== 1'b0) begin
            chk("old_stack", mp_u.store[sp - 4], 32'h5a5a_5a5a);
            chk("new_stack", mp_u.store[DSP - 4], 32'h5a5a_5a5a);
            return;
        end
        sw = t == `TYPE_ACCESS && s >= `ST_SP_MIN;
        n = (o == `OPT_STACK && sw) ? (int'(ac) + 3) / 4 : 0;
        top = sw ? DSP - 32'(4 * n) : sp;
        fb = top - `FRAME_BYTES;
        chk("frame0", mp_u.store[fb], {o, t, t == `TYPE_ACCESS ? cl : 8'h0, 16'h0});
        chk("frame1", mp_u.store[fb + 4], {ac, cc, rg, 12'h0});
        chk("frame2", mp_u.store[fb + 8], DSC);
        chk("frame3", mp_u.store[fb + 12], c.pc_next);
        chk("frame4", mp_u.store[fb + 16], sp);
        chk("frame5", mp_u.store[fb + 20], rv);
        for (int k = 0; k < n; k++)
            chk("arg", mp_u.store[top + 4 * k], mp_u.store[sp + 4 * k]);
        chk("sp", got.sp, fb);
        chk("pc", got.pc, ENT + `ENTRY_STEP);
        chk("reg", {got.reg_we, got.reg_sel}, {1'b1, rg});
        chk("reg_rd_sel", 32'(reg_rd_sel), 32'(rg));
        chk("data_ptr", got.reg_val, rg == `EREG_SP ? fb : DAP);
        chk("ial", mp_u.cst.exists(`AL_BASE + `AL_IAL), t == `TYPE_ACCESS);
        if (t == `TYPE_ACCESS) begin
            chk("ial_val", mp_u.cst[`AL_BASE + `AL_IAL], {lv, 24'h0});
            chk("daddr", mp_u.cst[`AL_BASE + `AL_DADDR + 32'(c.fc) * 4], DSC);
        end
        // a plain frame is corrupted, a type 01 return is refused
        if (br && t == `TYPE_PLAIN)
            mp_u.store[fb] = {3'h2, 5'h12, cl, 16'h0};
        status <= br ? 8'h0 : 8'h1;
        c.ret = 1'b1;
        c.sp = fb;
        run(c);
        chk("ret_fmt", 32'(g_fmt), 32'(br));
        if (br) begin
            chk("ret_keep", got.sp, fb);
            return;
        end
        chk("ret_sp", got.sp, sp + 32'(ac));
        chk("ret_pc", got.pc, c.pc_next);
        chk("ret_ccr", {got.ccr_we, got.condition_code_bits}, {1'b1, cc});
        chk("ret_reg", got.reg_val, rv);
        if (t == `TYPE_ACCESS)
            chk("dal", mp_u.cst[`AL_BASE + `AL_DAL], {cl, 24'h0});
    endtask

    initial begin
        void'($urandom(32'h91f9));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        call_case(`OPT_STACK, `TYPE_PLAIN, 8'h1, 4'h3, 8'h8, 0, 1'b0);
        call_case(`OPT_INDIRECT, `TYPE_PLAIN, 8'h1, `EREG_SP, 8'h4, 0, 1'b0);
        for (int i = 1; i < 8; i++) begin
            call_case(`OPT_STACK, `TYPE_ACCESS, 8'(i), 4'h9, 8'hd, 0, 1'b0);
            call_case(`OPT_INDIRECT, `TYPE_ACCESS, 8'(i), 4'ha, 8'h6, 0, 1'b0);
        end
        for (int i = 0; i < 8; i++)
            call_case(3'(i), `TYPE_PLAIN, 8'h1, 4'h2, 8'h0, 0, 1'b0);
        for (int i = 2; i < 32; i++)
            call_case(`OPT_STACK, 5'(i), 8'h1, 4'h2, 8'h0, 0, 1'b0);
        call_case(`OPT_STACK, `TYPE_ACCESS, 8'h0, 4'h1, 8'h4, 0, 1'b0);
        call_case(`OPT_STACK, `TYPE_ACCESS, 8'h9, 4'h1, 8'h4, 0, 1'b0);
        call_case(`OPT_STACK, `TYPE_PLAIN, 8'h1, 4'h1, 8'h4, 1, 1'b0);
        call_case(`OPT_STACK, `TYPE_ACCESS, 8'h4, 4'h1, 8'h4, 2, 1'b0);
        call_case(`OPT_INDIRECT, `TYPE_ACCESS, 8'h2, 4'h5, 8'h4, 0, 1'b1);
        call_case(`OPT_STACK, `TYPE_PLAIN, 8'h1, 4'h6, 8'h4, 0, 1'b1);
        for (int i = 0; i < 40; i++)
            call_case(3'($urandom_range(1, 0) * 4), 5'($urandom_range(1, 0)),
                8'($urandom_range(7, 1)), 4'($urandom), 8'($urandom_range(15, 0)), 0, 1'b0);
        print_verdict();
    end
endmodule
